//--- hdl/iror_monitor_sel.sv
`timescale 1ns/100ps
`include "iror_regs.svh"
// holds monitor index, registers selected sample
module iror_monitor_sel
	import iror_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_sync_b,
	input wire logic clk_en,
	// index write
	input wire logic idx_wr,
	input wire iror_mon_idx_t idx_wdata,
	// monitor sample source
	input wire iror_mon_code_t mon_code_in,
	// selected index and code
	output iror_mon_idx_t mon_index,
	output iror_mon_code_t mon_code
);
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mon_index <= `IROR_MON_INDEX_RESET;
		end else if (clk_en && idx_wr) begin
			mon_index <= idx_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mon_code <= '0;
		end else if (clk_en) begin
			mon_code <= mon_code_in;
		end
	end
endmodule

//--- hdl/iror_regs.sv
`timescale 1ns/100ps
`include "iror_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Claim a 4K byte window; decode all registers inside it.
// - Accept 32, 16 and 8-bit accesses except 32-bit-only registers.
// - Unused offsets complete normally and read zero, including 0x0C to 0x44.
// - Writing one to reset register bit 0 clears all outputs.
// - Undefined register bits stay low and read zero.
// - Location bits 2:0 report carrier site A to D.
// - Location bits 7:3 give carrier slot id; bits 31:8 read zero.
// - Output register maps ports A to D onto bytes 0 to 3.
// - A one closes a channel switch, a zero opens it.
// - Reading output register returns last written channel states.
// - Power-up and software reset force all output bits to zero.
// - System reset from host software also clears outputs.
// - Monitor data register accesses monitor register chosen by index.
// - Monitor read: index in 22:16, code in 15:6, 5:0 zero.
// - Host writes index first; device echoes it in data bits 22:16.
// - Valid indices 0x00-0x02, 0x20-0x22, 0x24-0x26.
// - Offset 0x200 returns firmware revision letter in low byte.
// - Target handles memory reads and writes, one 4K window.
// - Device never raises an interrupt; host polls.
module iror_regs
	import iror_pkg::*;
#(
	parameter logic [7:0] FW_REV_LETTER = 8'h5A // arbitrary value
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// system reset from host software
	input wire logic sys_soft_rst,
	// memory window access, one cycle strobes; polled only, no interrupt
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [`IROR_WIN_BITS-1:0] mem_addr,
	input wire iror_be_t mem_be,
	input wire iror_word_t mem_wdata,
	output iror_word_t mem_rdata,
	output logic mem_rvalid,
	// carrier location straps
	input wire logic [2:0] carrier_site,
	input wire logic [4:0] carrier_slot,
	// on-chip monitor samples per index
	input wire iror_mon_code_t mon_sample_in,
	output iror_mon_idx_t mon_sel_index,
	// switch drives
	output iror_word_t relay_drive_bits
);
	////////////////////////////////////////////////////////////////////////////
	logic rst_meta_reg;
	logic rst_sync_b;
	logic [11:0] word_addr;
	logic hit_reset, hit_loc, hit_out, hit_mdata, hit_midx, hit_fw;
	logic full_word;
	logic soft_clear;
	iror_word_t out_reg;
	iror_word_t out_next;
	iror_word_t rdata_next;
	iror_mon_idx_t mon_index;
	iror_mon_code_t mon_code;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address decode, word aligned inside 4K window
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign word_addr = {mem_addr[11:2], 2'b00};
	assign hit_reset = hit(word_addr, `IROR_OFF_SOFT_RESET);
	assign hit_loc = hit(word_addr, `IROR_OFF_LOCATION);
	assign hit_out = hit(word_addr, `IROR_OFF_OUTPUT);
	assign hit_mdata = hit(word_addr, `IROR_OFF_MON_DATA);
	assign hit_midx = hit(word_addr, `IROR_OFF_MON_INDEX);
	assign hit_fw = hit(word_addr, `IROR_OFF_FW_REV);
	assign full_word = (mem_be == 4'hF);

	assign soft_clear = (clk_en && mem_wr && hit_reset && mem_be[0]
		&& mem_wdata[`IROR_SOFT_RESET_BIT]) || (clk_en && sys_soft_rst);

	////////////////////////////////////////////////////////////////////////////
	// output register with byte lanes
	always_comb begin
		out_next = out_reg;
		for (int b = 0; b < 4; b++) begin
			if (mem_be[b]) begin
				out_next[b*8 +: 8] = mem_wdata[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			out_reg <= `IROR_OUTPUT_RESET;
		end else if (soft_clear) begin
			out_reg <= `IROR_OUTPUT_RESET;
		end else if (clk_en && mem_wr && hit_out) begin
			out_reg <= out_next;
		end
	end

	assign relay_drive_bits = out_reg;

	////////////////////////////////////////////////////////////////////////////
	iror_monitor_sel u_mon (
		.core_clk(core_clk),
		.rst_sync_b(rst_sync_b),
		.clk_en(clk_en),
		.idx_wr(mem_wr && hit_midx && full_word),
		.idx_wdata(mem_wdata[`IROR_MON_IDX_W-1:0]),
		.mon_code_in(mon_sample_in),
		.mon_index(mon_index),
		.mon_code(mon_code)
	);
	assign mon_sel_index = mon_index;

	////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped reads return zero
	always_comb begin
		rdata_next = '0;
		if (hit_loc) begin
			rdata_next[`IROR_SITE_LSB +: `IROR_SITE_W] = carrier_site;
			rdata_next[`IROR_SLOT_LSB +: `IROR_SLOT_W] = carrier_slot;
		end else if (hit_out) begin
			rdata_next = out_reg;
		end else if (hit_mdata && full_word) begin
			rdata_next[`IROR_MON_IDX_LSB +: `IROR_MON_IDX_W] = mon_index;
			rdata_next[`IROR_MON_CODE_LSB +: `IROR_MON_CODE_W] = mon_code;
		end else if (hit_fw) begin
			rdata_next[7:0] = FW_REV_LETTER;
		end
		for (int b = 0; b < 4; b++) begin
			if (!mem_be[b]) begin
				rdata_next[b*8 +: 8] = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mem_rdata <= '0;
			mem_rvalid <= 1'b0;
		end else if (clk_en) begin
			mem_rvalid <= mem_rd;
			if (mem_rd) begin
				mem_rdata <= rdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_soft_reset_clears;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_reset && mem_be[0] && mem_wdata[0]) |=> (relay_drive_bits == '0);
	endproperty
	a_soft_reset_clears: assert property (p_soft_reset_clears)
		else $error("soft reset kept outputs");

	property p_sys_reset_clears;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && sys_soft_rst) |=> (relay_drive_bits == '0);
	endproperty
	a_sys_reset_clears: assert property (p_sys_reset_clears)
		else $error("sys reset kept outputs");

	property p_full_write;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_out && mem_be == 4'hF && !soft_clear)
			|=> (relay_drive_bits == $past(mem_wdata));
	endproperty
	a_full_write: assert property (p_full_write) else $error("output write lost");

	property p_byte_keep;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_out && !mem_be[3] && !soft_clear)
			|=> (relay_drive_bits[31:24] == $past(relay_drive_bits[31:24]));
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("unselected port changed");

	property p_readback;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_out && mem_be == 4'hF)
			|=> (mem_rvalid && mem_rdata == $past(out_reg));
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_unused_zero;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && !(hit_loc || hit_out || hit_mdata || hit_fw))
			|=> (mem_rvalid && mem_rdata == '0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused offset nonzero");

	property p_loc_read;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_loc && mem_be == 4'hF)
			|=> (mem_rdata == {24'h0, $past(carrier_slot), $past(carrier_site)});
	endproperty
	a_loc_read: assert property (p_loc_read) else $error("location read wrong");

	property p_mon_echo;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_mdata && full_word)
			|=> (mem_rdata[22:16] == $past(mon_index) && mem_rdata[5:0] == 6'h00);
	endproperty
	a_mon_echo: assert property (p_mon_echo)
		else $error("monitor index not echoed");

	property p_idx_capture;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_midx && full_word)
			|=> (mon_sel_index == $past(mem_wdata[6:0]));
	endproperty
	a_idx_capture: assert property (p_idx_capture)
		else $error("monitor index not taken");

	property p_idx_partial_ignored;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_midx && !full_word)
			|=> $stable(mon_sel_index);
	endproperty
	a_idx_partial_ignored: assert property (p_idx_partial_ignored)
		else $error("narrow index write taken");

	property p_mon_partial_zero;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_mdata && !full_word)
			|=> (mem_rdata == '0);
	endproperty
	a_mon_partial_zero: assert property (p_mon_partial_zero)
		else $error("narrow monitor read nonzero");

	property p_mon_code;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_mdata && full_word)
			|=> (mem_rdata[15:6] == $past(mon_code) && mem_rdata[31:23] == 9'h000);
	endproperty
	a_mon_code: assert property (p_mon_code)
		else $error("monitor code field wrong");

	property p_mon_data_write_ignored;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_mdata && !sys_soft_rst)
			|=> ($stable(mon_sel_index) && $stable(relay_drive_bits));
	endproperty
	a_mon_data_write_ignored: assert property (p_mon_data_write_ignored)
		else $error("monitor data write disturbed state");

	property p_loc_partial;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_loc && mem_be == 4'h1)
			|=> (mem_rdata == {24'h0, $past(carrier_slot), $past(carrier_site)});
	endproperty
	a_loc_partial: assert property (p_loc_partial)
		else $error("location byte read wrong");

	property p_port_b_write;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_out && mem_be[1] && !soft_clear)
			|=> (relay_drive_bits[15:8] == $past(mem_wdata[15:8]));
	endproperty
	a_port_b_write: assert property (p_port_b_write)
		else $error("port B byte not written");

	property p_port_d_write;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_out && mem_be[3] && !soft_clear)
			|=> (relay_drive_bits[31:24] == $past(mem_wdata[31:24]));
	endproperty
	a_port_d_write: assert property (p_port_d_write)
		else $error("port D byte not written");

	property p_port_a_keep;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_out && !mem_be[0] && !soft_clear)
			|=> (relay_drive_bits[7:0] == $past(relay_drive_bits[7:0]));
	endproperty
	a_port_a_keep: assert property (p_port_a_keep)
		else $error("port A changed without enable");

	property p_unused_write_keeps;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && !hit_out && !hit_reset && !sys_soft_rst)
			|=> $stable(relay_drive_bits);
	endproperty
	a_unused_write_keeps: assert property (p_unused_write_keeps)
		else $error("unused write changed outputs");

	property p_reset_reg_other_bits;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_wr && hit_reset && !(mem_be[0] && mem_wdata[0]) && !sys_soft_rst)
			|=> $stable(relay_drive_bits);
	endproperty
	a_reset_reg_other_bits: assert property (p_reset_reg_other_bits)
		else $error("reset reg upper bits acted");

	property p_lane_zero;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && !mem_be[3])
			|=> (mem_rdata[31:24] == 8'h00);
	endproperty
	a_lane_zero: assert property (p_lane_zero)
		else $error("disabled lane read nonzero");

	property p_rvalid;
		@(posedge core_clk) disable iff (!rst_sync_b)
		clk_en
			|=> (mem_rvalid == $past(mem_rd));
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read valid not one cycle after read");

	property p_rdata_hold;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && !mem_rd)
			|=> $stable(mem_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without read");

	property p_freeze;
		@(posedge core_clk) disable iff (!rst_sync_b)
		!clk_en
			|=> ($stable(relay_drive_bits) && $stable(mem_rdata) && $stable(mem_rvalid)
				&& $stable(mon_sel_index));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_fw_read;
		@(posedge core_clk) disable iff (!rst_sync_b)
		(clk_en && mem_rd && hit_fw && mem_be == 4'hF) |=> (mem_rdata == {24'h0, FW_REV_LETTER});
	endproperty
	a_fw_read: assert property (p_fw_read) else $error("revision read wrong");
endmodule

//--- shared/iror_pkg.sv
package iror_pkg;
	typedef logic [31:0] iror_word_t;
	typedef logic [3:0] iror_be_t;
	typedef logic [6:0] iror_mon_idx_t;
	typedef logic [9:0] iror_mon_code_t;
endpackage

//--- shared/iror_regs.svh
`ifndef IROR_REGS_SVH
`define IROR_REGS_SVH
`define IROR_WIN_BITS 12
`define IROR_OFF_SOFT_RESET 12'h000
`define IROR_OFF_LOCATION 12'h004
`define IROR_OFF_OUTPUT 12'h008
`define IROR_OFF_MON_DATA 12'h048
`define IROR_OFF_MON_INDEX 12'h04C
`define IROR_OFF_FW_REV 12'h200
`define IROR_SOFT_RESET_BIT 0
`define IROR_SITE_LSB 0
`define IROR_SITE_W 3
`define IROR_SLOT_LSB 3
`define IROR_SLOT_W 5
`define IROR_MON_IDX_LSB 16
`define IROR_MON_IDX_W 7
`define IROR_MON_CODE_LSB 6
`define IROR_MON_CODE_W 10
`define IROR_OUTPUT_RESET 32'h0000_0000
`define IROR_MON_INDEX_RESET 7'h00
`endif

//--- tb/iror_host_model.sv
`timescale 1ns/100ps
// host end of the memory window
module iror_host_model
	import iror_pkg::*;
(
	// clock
	input wire logic core_clk,
	// window access
	output logic mem_wr,
	output logic mem_rd,
	output logic [11:0] mem_addr,
	output iror_be_t mem_be,
	output iror_word_t mem_wdata,
	input wire iror_word_t mem_rdata,
	input wire logic mem_rvalid
);
	logic to;
	initial begin
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_addr = 12'h000;
		mem_be = 4'hF;
		mem_wdata = 32'h0;
		to = 1'b0;
	end
	// offset only: base is added before the window
	task automatic wr(input logic [11:0] a, input iror_be_t b, input iror_word_t d);
		@(negedge core_clk);
		mem_addr = a;
		mem_be = b;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(negedge core_clk);
		mem_wr = 1'b0;
		mem_wdata = ~d;
	endtask
	task automatic rd(input logic [11:0] a, input iror_be_t b, output iror_word_t d);
		@(negedge core_clk);
		mem_addr = a;
		mem_be = b;
		mem_rd = 1'b1;
		@(negedge core_clk);
		mem_rd = 1'b0;
		for (int n = 0; n < 4 && mem_rvalid !== 1'b1; n++) @(negedge core_clk);
		to = (mem_rvalid !== 1'b1);
		d = mem_rdata;
	endtask
	// index first, full words only
	task automatic mon(input logic [6:0] idx, output iror_word_t d);
		wr(12'h04C, 4'hF, {25'h0, idx});
		rd(12'h048, 4'hF, d);
	endtask
endmodule

//--- tb/test_iror_regs.sv
`timescale 1ns/100ps
module test_iror_regs;
	import iror_pkg::*;
	localparam logic [7:0] FW_REV = 8'h52; // arbitrary value
	logic core_clk, rst_b, sys_soft_rst, clk_en;
	logic [2:0] site;
	logic [4:0] slot;
	iror_mon_code_t code;
	iror_mon_idx_t idx_o;
	iror_be_t be;
	iror_word_t relay, shadow, d, r;
	wire logic mem_wr, mem_rd, mem_rvalid;
	wire logic [11:0] mem_addr;
	wire iror_be_t mem_be;
	wire iror_word_t mem_wdata, mem_rdata;
	int mismatches, comparisons;
	logic [6:0] idx_tab [9] = '{7'h00, 7'h01, 7'h02, 7'h20, 7'h21, 7'h22, 7'h24, 7'h25, 7'h26};

	iror_host_model h (.core_clk(core_clk), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
	iror_regs #(.FW_REV_LETTER(FW_REV)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.clk_en(clk_en), .sys_soft_rst(sys_soft_rst), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .carrier_site(site), .carrier_slot(slot),
		.mon_sample_in(code), .mon_sel_index(idx_o), .relay_drive_bits(relay));

	////////////////////////////////////////////////////////////////////////////
	function automatic iror_word_t merge(iror_word_t o, iror_word_t n, iror_be_t b);
		for (int k = 0; k < 4; k++) if (b[k]) o[8*k+:8] = n[8*k+:8];
		return o;
	endfunction
	task automatic chk(input string nm, input iror_word_t e, input iror_word_t g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic guard();
		if (h.to) begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input iror_be_t b, input iror_word_t e, input string nm);
		h.rd(a, b, r);
		guard();
		chk(nm, e, r);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{rst_b, sys_soft_rst, site, slot, code, shadow} = '0;
		clk_en = 1'b1;
		{mismatches, comparisons} = '0;
		void'($urandom(32'h5718));
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("relay power-up", 32'h0, relay);
		for (int i = 0; i < 4; i++) begin
			site = i[2:0];
			slot = 5'($urandom);
			rdc(12'h004, 4'hF, {24'h0, slot, site}, "location");
			rdc(12'h004, 4'h1, {24'h0, slot, site}, "location byte");
		end
		$display("test location done");
		for (int i = 0; i < 20; i++) begin
			be = (i < 4) ? 4'h1 << i : 4'($urandom);
			d = $urandom;
			h.wr(12'h008, be, d);
			shadow = merge(shadow, d, be);
			chk("relay drive", shadow, relay);
			rdc(12'h008, 4'hF, shadow, "output readback");
		end
		rdc(12'h008, 4'h2, shadow & 32'h0000_FF00, "byte readback");
		$display("test outputs done");
		for (int a = 12'h00C; a <= 12'h044; a += 4) begin
			h.wr(a[11:0], 4'hF, $urandom);
			rdc(a[11:0], 4'hF, 32'h0, "unused offset");
		end
		rdc(12'hFFC, 4'hF, 32'h0, "window top");
		rdc(12'h000, 4'hF, 32'h0, "reset reg read");
		chk("relay kept", shadow, relay);
		h.wr(12'h000, 4'hF, 32'hFFFF_FFFE);
		chk("relay bit0 clear", shadow, relay);
		h.wr(12'h000, 4'h1, 32'h0000_0001);
		chk("relay soft reset", 32'h0, relay);
		h.wr(12'h008, 4'hF, 32'hA5C3_0FF0);
		@(negedge core_clk) sys_soft_rst = 1'b1;
		@(negedge core_clk) sys_soft_rst = 1'b0;
		chk("relay system reset", 32'h0, relay);
		@(negedge core_clk) clk_en = 1'b0;
		d = $urandom | 32'h0000_0001;
		h.wr(12'h008, 4'hF, d);
		@(negedge core_clk) clk_en = 1'b1;
		chk("relay frozen", 32'h0, relay);
		$display("test resets done");
		for (int i = 0; i < 9; i++) begin
			code = 10'($urandom);
			h.mon(idx_tab[i], r);
			guard();
			chk("monitor index", {25'h0, idx_tab[i]}, {25'h0, idx_o});
			chk("monitor data", {9'h0, idx_tab[i], code, 6'h00}, r);
		end
		h.wr(12'h04C, 4'h1, 32'h0000_007F);
		chk("monitor index narrow", {25'h0, idx_tab[8]}, {25'h0, idx_o});
		h.wr(12'h048, 4'hF, 32'hFFFF_FFFF);
		chk("monitor data write", {25'h0, idx_tab[8]}, {25'h0, idx_o});
		rdc(12'h048, 4'h3, 32'h0, "monitor narrow read");
		rdc(12'h200, 4'hF, {24'h0, FW_REV}, "firmware rev");
		$display("test monitor done");
		h.wr(12'h008, 4'hF, 32'hFFFF_FFFF);
		chk("relay before reset", 32'hFFFF_FFFF, relay);
		@(negedge core_clk) rst_b = 1'b0;
		@(negedge core_clk) rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("relay mid-run reset", 32'h0, relay);
		h.wr(12'h008, 4'h4, 32'h00C3_0000);
		chk("relay after reset", 32'h00C3_0000, relay);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
